//--- rtl/pic_core.sv
// Eight-input priority interrupt controller with rotation, poll and cascading.
// Assumes all strobes, data and request lines are synchronous to clk.
//
// Summary of operation
// R1: Serviced level drops to lowest priority automatically.
// R2: Rotate with end-of-service rotates around serviced level.
// R3: Rotate alone sets the automatic rotation flag.
// R4: Software picks bottom level; next one becomes highest.
// R5: Rotate plus specific takes level bits as bottom.
// R6: Software priority change applies at command write.
// R7: Level trigger mode takes high level as request.
// R8: Level source drops request before end-of-service.
// R9: Status read returns request or in-service register.
// R10: Read selection retained until changed or poll.
// R11: Initialization selects the request register for reads.
// R12: Reads with select bit high return mask.
// R13: Poll with read enable returns the poll word.
// R14: Acknowledge clears highest pending request bit.
// R15: One master and eight slaves via cascade code.
// R16: Selected slave supplies vector bytes after first pulse.
// R17: Master cascade lines low idle, code during sequence.
// R18: Master drives cascade code for every input.
// R19: Edge mode creates request on rising edge.
// R20: Select bit picks mask or command access; chip select low.
// R21: Cascade lines output on master, input on slave.
// R22: Dual pin: transceiver enable or master select input.
// R23: Plain priority command clears the rotation flag.
// R24: Interrupt output when pending outranks all in service.
module pic_core
   import pic_pkg::*;
(
   // Clock and reset.
   input  wire logic          clk,
   input  wire logic          nrst,
   // Processor bus.
   input  wire pic_cpu_bus_t  cpu,
   input  wire logic [7:0]    data_in,
   output logic [7:0]         data_out,
   output logic               data_oe,
   output logic               int_req,
   // Peripheral requests.
   input  wire logic [7:0]    request_inputs,
   // Cascade bus and dual-function pin.
   input  wire logic [2:0]    cascade_lines_in,
   output logic [2:0]         cascade_lines_out,
   output logic               cascade_lines_oe,
   input  wire logic          master_select_or_buffer_enable_in,
   output logic               master_select_or_buffer_enable_out,
   output logic               master_select_or_buffer_enable_oe
);

   pic_cpu_bus_t cpu_q;
   pic_init_t    cfg_r;
   pic_setup_t   setup_r;
   logic [7:0]   req_q;
   logic [7:0]   pending_request_r;
   logic [7:0]   in_service_r;
   logic [7:0]   channel_mask_r;
   logic [2:0]   bottom_r;
   logic         auto_rot_r;
   logic         read_in_service_r;
   logic         poll_arm_r;
   logic         poll_reading_r;
   logic [7:0]   poll_word_r;
   logic [1:0]   ack_cnt_r;
   logic [2:0]   ack_level_r;
   logic         ack_mine_r;
   logic         casc_busy_r;
   logic [2:0]   casc_out_r;
   logic [7:0]   data_out_r;
   logic         data_oe_r;
   logic         int_r;

   // Returns {found, level} of the highest-priority set bit for a given bottom level.
   function automatic logic [3:0] top_of(input logic [7:0] v, input logic [2:0] bot);
      logic [3:0] res;
      logic [2:0] lv;
      res = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         lv = bot + 3'(i) + 3'h1;
         if (v[lv]) begin
            res = {1'b1, lv};
         end
      end
      return res;
   endfunction

   // Zero is the highest rank.
   function automatic logic [2:0] rank_of(input logic [2:0] lv, input logic [2:0] bot);
      return lv - bot - 3'h1;
   endfunction

   // Strobe edges; chip select qualifies reads and writes, not acknowledge.
   logic rd_fall, rd_rise, wr_rise, ack_fall, ack_rise;
   assign rd_fall  = cpu_q.rd_n && !cpu.rd_n && !cpu.cs_n;
   assign rd_rise  = !cpu_q.rd_n && cpu.rd_n;
   assign wr_rise  = !cpu_q.wr_n && cpu.wr_n && !cpu.cs_n;
   assign ack_fall = cpu_q.acknowledge_strobe_n && !cpu.acknowledge_strobe_n;
   assign ack_rise = !cpu_q.acknowledge_strobe_n && cpu.acknowledge_strobe_n;

   logic sel_hi, init_start, mask_write, setup_write, pc_write, rs_write;
   assign sel_hi      = cpu.register_select_bit;
   assign init_start  = wr_rise && !sel_hi && data_in[W1_MARK_BIT];  // [R20]
   assign mask_write  = wr_rise && sel_hi && setup_r == SETUP_READY;  // [R20]
   assign setup_write = wr_rise && sel_hi && setup_r != SETUP_READY;
   assign pc_write    = wr_rise && !sel_hi && !data_in[W1_MARK_BIT] && !data_in[CMD_KIND_BIT];
   assign rs_write    = wr_rise && !sel_hi && !data_in[W1_MARK_BIT] && data_in[CMD_KIND_BIT];

   // Role: master in single mode; else dual pin decides when unbuffered, the fourth word when buffered.
   logic is_master;
   assign is_master = cfg_r.single ||
                      (cfg_r.buffered ? cfg_r.master_cfg : master_select_or_buffer_enable_in); // [R22]

   logic [3:0] top_req, top_srv;
   logic       int_cond;
   assign top_req  = top_of(pending_request_r & ~channel_mask_r, bottom_r);
   assign top_srv  = top_of(in_service_r, bottom_r);
   assign int_cond = top_req[3] &&
                     (!top_srv[3] || rank_of(top_req[2:0], bottom_r) <
                                      rank_of(top_srv[2:0], bottom_r));   // [R24]

   // An acknowledge commits a slave only when the master names it on the second pulse.
   logic [1:0] last_pulse;
   logic       casc_match, ack_commit, poll_commit, commit, ack_last_end;
   assign last_pulse   = cfg_r.two_pulse ? PULSE_SECOND : PULSE_THIRD;
   assign casc_match   = cascade_lines_in == cfg_r.casc_cfg[2:0];          // [R21]
   assign ack_commit   = ack_fall && ((is_master && ack_cnt_r == 2'h0) ||
                         (!is_master && ack_cnt_r == PULSE_FIRST && casc_match)); // [R15]
   assign poll_commit  = rd_fall && poll_arm_r;
   assign commit       = ack_commit || poll_commit;
   assign ack_last_end = ack_rise && ack_cnt_r == last_pulse;

   logic [7:0] commit_vec;
   assign commit_vec = (commit && top_req[3]) ? (8'h01 << top_req[2:0]) : 8'h00;

   // End-of-service level: commanded specific, commanded highest, or automatic.
   logic       eos_do, eos_rot;
   logic [2:0] eos_lvl;
   always_comb begin
      eos_do  = 1'b0;
      eos_rot = 1'b0;
      eos_lvl = top_srv[2:0];
      if (pc_write && data_in[PC_EOS]) begin
         eos_do  = data_in[PC_SPECIFIC] || top_srv[3];
         eos_rot = data_in[PC_ROTATE];                                    // [R2]
         eos_lvl = data_in[PC_SPECIFIC] ? data_in[2:0] : top_srv[2:0];
      end else if (ack_last_end && cfg_r.auto_eos && top_srv[3]) begin
         eos_do  = 1'b1;
         eos_rot = auto_rot_r;                                            // [R1] [R3]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cpu_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                    register_select_bit: 1'b0, acknowledge_strobe_n: 1'b1};
         req_q <= 8'h00;
      end else begin
         cpu_q <= cpu;
         req_q <= request_inputs;
      end
   end

   // Initialization sequence.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         setup_r <= SETUP_READY;
         cfg_r   <= '0;
      end else if (init_start) begin
         setup_r          <= SETUP_W2;
         cfg_r            <= '0;
         cfg_r.need_w4    <= data_in[W1_NEED_W4];
         cfg_r.single     <= data_in[W1_SINGLE];
         cfg_r.level_trig <= data_in[W1_LEVEL_TRIG];                     // [R7]
         cfg_r.addr_low   <= data_in[7:5];
      end else if (setup_write) begin
         unique case (setup_r)
            SETUP_W2: begin
               cfg_r.vec_base <= data_in;
               setup_r <= !cfg_r.single ? SETUP_W3 : (cfg_r.need_w4 ? SETUP_W4 : SETUP_READY);
            end
            SETUP_W3: begin
               cfg_r.casc_cfg <= data_in;
               setup_r <= cfg_r.need_w4 ? SETUP_W4 : SETUP_READY;
            end
            SETUP_W4: begin
               cfg_r.two_pulse  <= data_in[W4_TWO_PULSE];
               cfg_r.auto_eos   <= data_in[W4_AUTO_EOS];
               cfg_r.master_cfg <= data_in[W4_MASTER];
               cfg_r.buffered   <= data_in[W4_BUFFERED];
               setup_r <= SETUP_READY;
            end
            SETUP_READY: setup_r <= SETUP_READY;
         endcase
      end
   end

   // Request capture; a new edge beats an acknowledge clear in the same cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pending_request_r <= 8'h00;
      end else if (init_start) begin
         pending_request_r <= 8'h00;
      end else if (cfg_r.level_trig) begin
         pending_request_r <= request_inputs & ~commit_vec;               // [R7] [R8]
      end else begin
         pending_request_r <= (request_inputs & ~req_q) |
                              (pending_request_r & request_inputs & ~commit_vec); // [R19] [R14]
      end
   end

   // In-service bits; a new acknowledge wins over a clear of the same bit.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_service_r <= 8'h00;
      end else if (init_start) begin
         in_service_r <= 8'h00;
      end else begin
         in_service_r <= (in_service_r & ~(eos_do ? (8'h01 << eos_lvl) : 8'h00)) | commit_vec;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         channel_mask_r <= RESET_MASK;
      end else if (init_start) begin
         channel_mask_r <= RESET_MASK;
      end else if (mask_write) begin
         channel_mask_r <= data_in;                                       // [R20]
      end
   end

   // Priority rotation and the automatic rotation flag.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bottom_r   <= RESET_BOTTOM;
         auto_rot_r <= 1'b0;
      end else if (init_start) begin
         bottom_r   <= RESET_BOTTOM;
         auto_rot_r <= 1'b0;
      end else begin
         if (eos_do && eos_rot) begin
            bottom_r <= eos_lvl;                                          // [R1] [R2]
         end else if (pc_write && data_in[PC_ROTATE] && data_in[PC_SPECIFIC]) begin
            bottom_r <= data_in[2:0];                                     // [R4] [R5] [R6]
         end
         if (pc_write && !data_in[PC_SPECIFIC] && !data_in[PC_EOS]) begin
            auto_rot_r <= data_in[PC_ROTATE];                             // [R3] [R23]
         end
      end
   end

   // Read selection and poll arming.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         read_in_service_r <= 1'b0;
         poll_arm_r        <= 1'b0;
      end else if (init_start) begin
         read_in_service_r <= 1'b0;                                       // [R11]
         poll_arm_r        <= 1'b0;
      end else if (rs_write) begin
         if (data_in[RS_ENABLE]) begin
            read_in_service_r <= data_in[RS_CHOICE];                      // [R9] [R10]
         end
         poll_arm_r <= data_in[RS_POLL];
      end else if (poll_commit) begin
         read_in_service_r <= 1'b0;                                       // [R10]
         poll_arm_r        <= 1'b0;
      end
   end

   // Acknowledge pulse counter and the level frozen at commit.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack_cnt_r   <= 2'h0;
         ack_level_r <= SPURIOUS_LVL;
         ack_mine_r  <= 1'b0;
      end else begin
         if (ack_last_end) begin
            ack_cnt_r <= 2'h0;
         end else if (ack_fall && ack_cnt_r != PULSE_THIRD) begin
            ack_cnt_r <= ack_cnt_r + 2'h1;
         end
         if (ack_commit) begin
            ack_level_r <= top_req[3] ? top_req[2:0] : SPURIOUS_LVL;
            ack_mine_r  <= !is_master || cfg_r.single ||
                           !cfg_r.casc_cfg[top_req[3] ? top_req[2:0] : SPURIOUS_LVL]; // [R16]
         end else if (ack_last_end) begin
            ack_mine_r  <= 1'b0;
         end
      end
   end

   // Master cascade code from end of first pulse to end of last pulse.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         casc_busy_r <= 1'b0;
         casc_out_r  <= 3'h0;
      end else if (ack_last_end || !is_master) begin
         casc_busy_r <= 1'b0;
         casc_out_r  <= 3'h0;                                             // [R17]
      end else if (ack_rise && ack_cnt_r == PULSE_FIRST) begin
         casc_busy_r <= 1'b1;
         casc_out_r  <= ack_level_r;                                      // [R17] [R18]
      end
   end

   // Read data: vector bytes during acknowledge, else poll word or status.
   logic [7:0] live_poll;
   assign live_poll = {top_req[3], 4'h0, top_req[2:0]};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         poll_reading_r <= 1'b0;
         poll_word_r    <= 8'h00;
      end else if (poll_commit) begin
         poll_reading_r <= 1'b1;
         poll_word_r    <= live_poll;
      end else if (rd_rise) begin
         poll_reading_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         data_out_r <= 8'h00;
         data_oe_r  <= 1'b0;
      end else if (!cpu.acknowledge_strobe_n && ack_cnt_r != 2'h0) begin
         data_oe_r <= ack_mine_r;                                         // [R16]
         unique case (ack_cnt_r)
            PULSE_FIRST: begin
               data_oe_r  <= is_master && !cfg_r.two_pulse;
               data_out_r <= CALL_OPCODE;
            end
            PULSE_SECOND: begin
               data_out_r <= cfg_r.two_pulse ? {cfg_r.vec_base[7:3], ack_level_r} :
                                               {cfg_r.addr_low, ack_level_r, 2'b00};
            end
            default: data_out_r <= cfg_r.vec_base;
         endcase
      end else if (!cpu.rd_n && !cpu.cs_n) begin
         data_oe_r <= 1'b1;
         if (poll_commit) begin
            data_out_r <= live_poll;                                      // [R13]
         end else if (poll_reading_r) begin
            data_out_r <= poll_word_r;
         end else if (sel_hi) begin
            data_out_r <= channel_mask_r;                                 // [R12]
         end else begin
            data_out_r <= read_in_service_r ? in_service_r : pending_request_r; // [R9]
         end
      end else begin
         data_oe_r <= 1'b0;
      end
   end

   // The interrupt output is held low from the poll command until the poll read begins, so a late arrival cannot raise the line.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         int_r <= 1'b0;
      end else begin
         int_r <= int_cond && !poll_arm_r;                                // [R24]
      end
   end

   assign data_out                           = data_out_r;
   assign data_oe                            = data_oe_r;
   assign int_req                            = int_r;
   assign cascade_lines_out                  = casc_out_r;
   assign cascade_lines_oe                   = is_master && !cfg_r.single;       // [R21]
   assign master_select_or_buffer_enable_out = !data_oe_r;                       // [R22]
   assign master_select_or_buffer_enable_oe  = cfg_r.buffered;                   // [R22]

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_first_pulse_end;
      is_master && ack_rise && ack_cnt_r == PULSE_FIRST && !ack_last_end;
   endsequence

   sequence s_plain_read(logic hi);
      rd_fall && !poll_arm_r && cpu.acknowledge_strobe_n && !wr_rise && sel_hi == hi;
   endsequence

   a_mask_readback: assert property (s_plain_read(1'b1) |=> data_oe_r && data_out_r == channel_mask_r) // [R12]
      else $error("mask read did not return the mask");
   a_status_select: assert property (s_plain_read(1'b0) |=>
      data_out_r == ($past(read_in_service_r) ? $past(in_service_r) : $past(pending_request_r))) // [R9]
      else $error("status read returned wrong register");
   a_poll_word: assert property (poll_commit && cpu.acknowledge_strobe_n |=>
      data_out_r == {$past(top_req[3]), 4'h0, $past(top_req[2:0])} && !poll_arm_r) // [R13]
      else $error("poll read returned wrong word");
   a_ack_clears_req: assert property (ack_commit && top_req[3] && !cfg_r.level_trig |=>
      !pending_request_r[$past(top_req[2:0])] && in_service_r[$past(top_req[2:0])]) // [R14]
      else $error("acknowledge did not move request into service");
   a_casc_code: assert property (s_first_pulse_end |=> casc_out_r == ack_level_r && casc_busy_r) // [R17]
      else $error("cascade code not driven after first pulse");
   a_casc_idle: assert property (!casc_busy_r |-> casc_out_r == 3'h0) // [R17]
      else $error("cascade lines not low while idle");
   a_auto_rotate: assert property (ack_last_end && cfg_r.auto_eos && auto_rot_r && top_srv[3]
      && !wr_rise |=> bottom_r == $past(top_srv[2:0])) // [R1]
      else $error("automatic rotation missed");
   a_set_bottom: assert property (pc_write && data_in[PC_ROTATE] && data_in[PC_SPECIFIC]
      && !data_in[PC_EOS] |=> bottom_r == $past(data_in[2:0])) // [R5]
      else $error("bottom level not taken from command");
   a_rot_flag: assert property (pc_write && !data_in[PC_SPECIFIC] && !data_in[PC_EOS] |=>
      auto_rot_r == $past(data_in[PC_ROTATE])) // [R23]
      else $error("rotation flag not updated");
   a_no_req_no_int: assert property (!top_req[3] |=> !int_r) // [R24]
      else $error("interrupt raised with nothing pending");

endmodule

//--- rtl/pic_pkg.sv
// Constants, field positions and carrier types of the priority interrupt controller.
// Assumes one 100 MHz clock and processor strobes already synchronous to it.
package pic_pkg;

   // First initialization word, written with the select bit low and bit 4 set.
   localparam int W1_MARK_BIT   = 4;
   localparam int W1_NEED_W4    = 0;
   localparam int W1_SINGLE     = 1;
   localparam int W1_LEVEL_TRIG = 3;
   // Fourth initialization word.
   localparam int W4_TWO_PULSE  = 0;
   localparam int W4_AUTO_EOS   = 1;
   localparam int W4_MASTER     = 2;
   localparam int W4_BUFFERED   = 3;
   // Command words written with the select bit low and bit 4 clear.
   localparam int CMD_KIND_BIT  = 3;
   localparam int PC_ROTATE     = 7;
   localparam int PC_SPECIFIC   = 6;
   localparam int PC_EOS        = 5;
   localparam int RS_POLL       = 2;
   localparam int RS_ENABLE     = 1;
   localparam int RS_CHOICE     = 0;

   localparam logic [2:0] RESET_BOTTOM = 3'h7;
   localparam logic [2:0] SPURIOUS_LVL = 3'h7;
   localparam logic [7:0] RESET_MASK   = 8'h00;
   localparam logic [1:0] PULSE_FIRST  = 2'h1;
   localparam logic [1:0] PULSE_SECOND = 2'h2;
   localparam logic [1:0] PULSE_THIRD  = 2'h3;
   // Opcode sent on the first of three acknowledge pulses; value is a plain default.
   localparam logic [7:0] CALL_OPCODE  = 8'hcd;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic register_select_bit;
      logic acknowledge_strobe_n;
   } pic_cpu_bus_t;

   typedef struct packed {
      logic       need_w4;
      logic       single;
      logic       level_trig;
      logic [2:0] addr_low;
      logic [7:0] vec_base;
      logic [7:0] casc_cfg;
      logic       two_pulse;
      logic       auto_eos;
      logic       master_cfg;
      logic       buffered;
   } pic_init_t;

   typedef enum logic [1:0] {
      SETUP_READY = 2'b00,
      SETUP_W2    = 2'b01,
      SETUP_W3    = 2'b10,
      SETUP_W4    = 2'b11
   } pic_setup_t;

endpackage

//--- verification/pic_cpu_model.sv
// Processor-side partner: drives the bus strobes, write data and acknowledge pulses.
// Assumes the controller samples every strobe on the rising edge of clk.
module pic_cpu_model
   import pic_pkg::*;
(
   // Clock.
   input  wire logic       clk,
   // Bus toward the controller.
   output pic_cpu_bus_t    cpu,
   output logic [7:0]      data_in,
   input  wire logic [7:0] data_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cpu     = '1;
      data_in = 8'h00;
   end

   // Data is held through the edge that sees the write strobe rise.
   task automatic wr(input logic a0, input logic [7:0] d);
      @(posedge clk);
      cpu.cs_n                <= 1'b0;
      cpu.register_select_bit <= a0;
      cpu.wr_n                <= 1'b0;
      data_in                 <= d;
      @(posedge clk);
      cpu.wr_n <= 1'b1;
      @(posedge clk);
      cpu.cs_n <= 1'b1;
      // A released bus shows the inverse rather than the last value.
      data_in <= ~d;
      @(negedge clk);
   endtask

   task automatic rd(input logic a0, output logic [7:0] q);
      @(posedge clk);
      cpu.cs_n                <= 1'b0;
      cpu.register_select_bit <= a0;
      cpu.rd_n                <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      q = data_out;
      @(posedge clk);
      cpu.cs_n <= 1'b1;
      cpu.rd_n <= 1'b1;
      @(negedge clk);
   endtask

   task automatic ack(output logic [7:0] q);
      @(posedge clk);
      cpu.acknowledge_strobe_n <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      q = data_out;
      @(posedge clk);
      cpu.acknowledge_strobe_n <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
endmodule

//--- verification/priority_interrupt_controller_tb_top.sv
// Self-checking bench of the priority interrupt controller.
// Assumes a master by pin with no slaves attached, later a slave by pin, and a processor partner model.
module priority_interrupt_controller_tb_top
   import pic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] VEC_BASE = 8'h48;

   logic         clk = 1'b0;
   logic         nrst = 1'b0;
   logic [7:0]   req = 8'h00;
   logic [2:0]   casc_in = 3'h0;
   logic         ms_in = 1'b1;
   pic_cpu_bus_t cpu;
   logic [7:0]   data_in, data_out;
   logic         int_req, casc_oe, ms_oe, data_oe, ms_out;
   logic [2:0]   casc_out;
   int           error_cnt = 0;
   int           compares = 0;
   int           cycles = 0;

   initial forever #5 clk = ~clk;

   pic_cpu_model u_cpu (.clk(clk), .cpu(cpu), .data_in(data_in), .data_out(data_out));

   pic_core u_dut (
      .clk(clk), .nrst(nrst), .cpu(cpu), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .int_req(int_req), .request_inputs(req),
      .cascade_lines_in(casc_in), .cascade_lines_out(casc_out),
      .cascade_lines_oe(casc_oe), .master_select_or_buffer_enable_in(ms_in),
      .master_select_or_buffer_enable_out(ms_out), .master_select_or_buffer_enable_oe(ms_oe));

   function automatic logic [7:0] poll_word(input logic [2:0] lvl);
      return {1'b1, 4'h0, lvl};
   endfunction

   function automatic logic [7:0] vec3p(input logic [7:0] w1, input logic [2:0] lvl);
      return {w1[7:5], lvl, 2'b00};
   endfunction

   task automatic final_report();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // The third word is the slave map of a master or the identity of a slave.
   task automatic init(input logic [7:0] w1, input logic [7:0] w3, input logic [7:0] w4);
      u_cpu.wr(1'b0, w1);
      u_cpu.wr(1'b1, VEC_BASE);
      u_cpu.wr(1'b1, w3);
      u_cpu.wr(1'b1, w4);
   endtask

   // Request lines change only just after a rising edge.
   task automatic set_req(input logic [7:0] v);
      @(posedge clk);
      req <= v;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      logic [7:0] q;
      logic [7:0] m;
      void'($urandom(32'hb5f6c3ed));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      init(8'hb1, 8'h00, 8'h00);
      chk("pin_oe", 8'h00, {7'h0, ms_oe});
      chk("casc_oe", 8'h01, {7'h0, casc_oe});
      for (int i = 0; i < 8; i++) begin
         m = 8'($urandom());
         u_cpu.wr(1'b1, m);
         u_cpu.rd(1'b1, q);
         chk("mask", m, q);
      end
      chk("rd_oe", 8'h01, {7'h0, data_oe});
      chk("buf_en", 8'h00, {7'h0, ms_out});
      u_cpu.wr(1'b1, 8'h00);
      set_req(8'h24);
      u_cpu.rd(1'b0, q);
      chk("pending", 8'h24, q);
      chk("int_req", 8'h01, {7'h0, int_req});
      u_cpu.ack(q);
      chk("opcode", CALL_OPCODE, q);
      chk("casc", 8'h02, {5'h0, casc_out});
      u_cpu.ack(q);
      chk("byte2", vec3p(8'hb1, 3'h2), q);
      u_cpu.ack(q);
      chk("byte3", VEC_BASE, q);
      chk("casc_idle", 8'h00, {5'h0, casc_out});
      chk("int_blocked", 8'h00, {7'h0, int_req});
      u_cpu.wr(1'b0, 8'h0b);
      u_cpu.rd(1'b0, q);
      chk("in_service", 8'h04, q);
      u_cpu.rd(1'b0, q);
      chk("in_service_again", 8'h04, q);
      u_cpu.wr(1'b0, 8'ha0);
      set_req(8'h26);
      u_cpu.wr(1'b0, 8'h0e);
      u_cpu.rd(1'b0, q);
      chk("poll_rotated", poll_word(3'h5), q);
      u_cpu.rd(1'b0, q);
      chk("pending_after_poll", 8'h02, q);
      set_req(8'h27);
      u_cpu.wr(1'b0, 8'hc0);
      u_cpu.wr(1'b0, 8'h0e);
      u_cpu.rd(1'b0, q);
      chk("poll_bottom", poll_word(3'h1), q);
      // The line stays high across the restart; only level sensing can see it.
      set_req(8'h40);
      init(8'hb9, 8'h00, 8'h01);
      u_cpu.rd(1'b0, q);
      chk("level_pending", 8'h40, q);
      u_cpu.ack(q);
      u_cpu.ack(q);
      chk("two_pulse_byte", {VEC_BASE[7:3], 3'h6}, q);
      set_req(8'h00);
      u_cpu.rd(1'b0, q);
      chk("level_dropped", 8'h00, q);
      // Automatic end of service, first with the rotation flag set, then cleared.
      init(8'hb1, 8'h00, 8'h02);
      u_cpu.wr(1'b0, 8'h80);
      set_req(8'h09);
      repeat (3) u_cpu.ack(q);
      set_req(8'h08);
      set_req(8'h09);
      u_cpu.wr(1'b0, 8'h0e);
      u_cpu.rd(1'b0, q);
      chk("poll_auto_rot", poll_word(3'h3), q);
      u_cpu.wr(1'b0, 8'h20);
      u_cpu.wr(1'b0, 8'h00);
      set_req(8'h29);
      repeat (3) u_cpu.ack(q);
      set_req(8'h21);
      set_req(8'h29);
      u_cpu.wr(1'b0, 8'h0e);
      u_cpu.rd(1'b0, q);
      chk("poll_rot_off", poll_word(3'h3), q);
      // Slave by pin: it answers only when the master names its identity.
      @(posedge clk);
      ms_in   <= 1'b0;
      casc_in <= 3'h3;
      init(8'hb1, 8'h03, 8'h00);
      chk("slave_casc_oe", 8'h00, {7'h0, casc_oe});
      set_req(8'h10);
      u_cpu.ack(q);
      u_cpu.ack(q);
      chk("slave_byte2", vec3p(8'hb1, 3'h4), q);
      u_cpu.ack(q);
      chk("slave_byte3", VEC_BASE, q);
      @(posedge clk);
      casc_in <= 3'h5;
      set_req(8'h30);
      repeat (3) u_cpu.ack(q);
      u_cpu.rd(1'b0, q);
      chk("slave_not_named", 8'h20, q);
      final_report();
   end
endmodule
